/* include/fqgt_consts.svh */
// query table word addresses, values and address width
`ifndef FQGT_CONSTS_SVH
`define FQGT_CONSTS_SVH
`define FQGT_ADDR_W        9
`define FQGT_GEO_BASE      9'h027
`define FQGT_GEO_LAST      9'h030
`define FQGT_EXT_BASE      9'h10A
`define FQGT_EXT_LAST      9'h142
`define FQGT_SIZE_256      8'h19
`define FQGT_SIZE_512      8'h1A
`define FQGT_SIZE_1G       8'h1B
`define FQGT_FEAT_SEP      8'hE6
`define FQGT_FEAT_SHR      8'h66
`define FQGT_PAGE_SEP      8'h05
`define FQGT_PAGE_SHR      8'h00
`define FQGT_SYNC_SEP      8'h03
`define FQGT_SYNC_SHR      8'h02
`define FQGT_BURST_CONT    3'h7
`define FQGT_UPPER_BYTE    8'h00
`endif

/* include/fqgt_pkg.sv */
// types shared by the query table modules
package fqgt_pkg;
	typedef enum logic [1:0] {
		FQGT_D256,
		FQGT_D512,
		FQGT_D1G
	} fqgt_density_e;
	typedef logic [8:0] fqgt_addr_t;
	typedef logic [7:0] fqgt_byte_t;
endpackage

/* include/fqgt_rom_if.sv */
// lookup request and answer between the read port and the table rom
`timescale 1ns/1ps
interface fqgt_rom_if;
	import fqgt_pkg::*;
	fqgt_addr_t    addr;
	fqgt_density_e density;
	logic          sep_bus;
	fqgt_byte_t    data;
	modport client (output addr, output density, output sep_bus, input data);
	modport rom    (input addr, input density, input sep_bus, output data);
endinterface

/* logic/fqgt_burst_enc.sv */
// encodes a burst length in words into its capability code
`timescale 1ns/1ps
`include "fqgt_consts.svh"
module fqgt_burst_enc
	import fqgt_pkg::*;
(
	input  wire logic [4:0] len_log2,
	input  wire logic       continuous,
	output logic      [2:0] code
);
	always_comb begin
		if (continuous) begin
			code = `FQGT_BURST_CONT; // [R16]
		end else begin
			code = 3'(len_log2 - 5'h01); // [R16]
		end
	end
endmodule

/* logic/fqgt_query.sv */
// registered query read port of the geometry and extended table
`timescale 1ns/1ps
`include "fqgt_consts.svh"
// What this block does
// R1: table byte drives low data byte, upper byte always zero.
// R2: word 27h gives log2 device bytes: 19h, 1Ah or 1Bh by density.
// R3: words 28h, 29h give bus width code 01h, 00h meaning x16.
// R4: words 2Ah, 2Bh give write buffer log2 size 0Ah, 00h.
// R5: word 2Ch gives one erase block region.
// R6: words 2Dh-30h give block count minus one and 256-byte size units.
// R7: extended table at 10Ah starts with tag string and version 1.4.
// R8: words 10Fh-112h give feature bits, page read bit by bus variant.
// R9: word 113h reports program allowed during erase suspend.
// R10: word 114h gives block status mask 33h, 115h zero.
// R11: words 116h and 117h give supply voltages 18h and 90h.
// R12: word 118h gives two otp fields; first field 80h,00h,03h,03h.
// R13: second protection field 89h, six zeros, then 10h,00h,04h.
// R14: word 127h gives page read size 05h or 00h by variant.
// R15: word 128h gives three burst configs: 02h, 03h, 07h.
// R16: burst code n means 2^(n+1) words, 07h continuous.
// R17: words 12Ch-131h give partition region count, size and ops.
// R18: words 132h-138h give cross-partition ops and block region.
// R19: words 139h-13Ch give endurance, cell bits and read modes.
// R20: words 13Dh-142h give programming region data.
// R21: undefined addresses and reserved bits read as zero.
module fqgt_query
	import fqgt_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          query_mode,
	input  wire logic          rd_en,
	input  wire logic [8:0]    word_addr,
	input  wire fqgt_density_e density,
	input  wire logic          separate_bus_variant,
	output logic      [15:0]   dq_out,
	output logic               dq_oe,
	output logic               rd_valid
);
	fqgt_rom_if rom_bus ();
	logic [15:0] dq_r;
	logic [15:0] dq_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        vld_r;
	logic        vld_nxt;

	assign rom_bus.addr    = word_addr;
	assign rom_bus.density = density;
	assign rom_bus.sep_bus = separate_bus_variant;

	fqgt_rom u_rom (.bus(rom_bus.rom));

	always_comb begin
		dq_nxt  = dq_r;
		oe_nxt  = 1'b0;
		vld_nxt = 1'b0;
		if (query_mode && rd_en) begin
			dq_nxt  = {`FQGT_UPPER_BYTE, rom_bus.data}; // [R1]
			oe_nxt  = 1'b1;
			vld_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_r  <= 16'h0000;
			oe_r  <= 1'b0;
			vld_r <= 1'b0;
		end else begin
			dq_r  <= dq_nxt;
			oe_r  <= oe_nxt;
			vld_r <= vld_nxt;
		end
	end

	assign dq_out   = dq_r;
	assign dq_oe    = oe_r;
	assign rd_valid = vld_r;

	a_upper_zero: assert property (@(posedge clk) disable iff (rst) rd_valid |-> dq_out[15:8] == 8'h00) // [R1]
		else $error("upper byte not zero");
	a_size_code: assert property (@(posedge clk) disable iff (rst) // [R2]
		(query_mode && rd_en && word_addr == 9'h027 && density == FQGT_D512) |=> dq_out == 16'h001A)
		else $error("device size code wrong");
	a_size_small: assert property (@(posedge clk) disable iff (rst) // [R2]
		(query_mode && rd_en && word_addr == 9'h027 && density == FQGT_D256) |=> dq_out == 16'h0019)
		else $error("small device size code wrong");
	a_width_code: assert property (@(posedge clk) disable iff (rst) // [R3]
		(query_mode && rd_en && word_addr == 9'h028) |=> dq_out == 16'h0001)
		else $error("width code wrong");
	a_buffer_size: assert property (@(posedge clk) disable iff (rst) // [R4]
		(query_mode && rd_en && word_addr == 9'h02A) |=> dq_out == 16'h000A)
		else $error("buffer size wrong");
	a_region_count: assert property (@(posedge clk) disable iff (rst) // [R5]
		(query_mode && rd_en && word_addr == 9'h02C) |=> dq_out == 16'h0001)
		else $error("region count wrong");
	a_block_count: assert property (@(posedge clk) disable iff (rst) // [R6]
		(query_mode && rd_en && word_addr == 9'h02E && density == FQGT_D1G) |=> dq_out == 16'h0001)
		else $error("block count high byte wrong");
	a_block_small: assert property (@(posedge clk) disable iff (rst) // [R6]
		(query_mode && rd_en && word_addr == 9'h02D && density == FQGT_D256) |=> dq_out == 16'h007F)
		else $error("block count low byte wrong");
	a_tag_start: assert property (@(posedge clk) disable iff (rst) // [R7]
		(query_mode && rd_en && word_addr == 9'h10A) |=> dq_out == 16'h0050)
		else $error("extended tag wrong");
	a_feature_var: assert property (@(posedge clk) disable iff (rst) // [R8]
		(query_mode && rd_en && word_addr == 9'h10F) |=> dq_out[7] == $past(separate_bus_variant))
		else $error("page read feature bit wrong");
	a_feature_hi: assert property (@(posedge clk) disable iff (rst) // [R8]
		(query_mode && rd_en && word_addr == 9'h110) |=> dq_out == 16'h0007)
		else $error("feature second byte wrong");
	a_suspend_prog: assert property (@(posedge clk) disable iff (rst) // [R9]
		(query_mode && rd_en && word_addr == 9'h113) |=> dq_out == 16'h0001)
		else $error("suspend support wrong");
	a_status_mask: assert property (@(posedge clk) disable iff (rst) // [R10]
		(query_mode && rd_en && word_addr == 9'h114) |=> dq_out == 16'h0033)
		else $error("status mask wrong");
	a_core_volts: assert property (@(posedge clk) disable iff (rst) // [R11]
		(query_mode && rd_en && word_addr == 9'h116) |=> dq_out == 16'h0018)
		else $error("core supply code wrong");
	a_prog_volts: assert property (@(posedge clk) disable iff (rst) // [R11]
		(query_mode && rd_en && word_addr == 9'h117) |=> dq_out == 16'h0090)
		else $error("programming supply code wrong");
	a_otp_fields: assert property (@(posedge clk) disable iff (rst) // [R12]
		(query_mode && rd_en && word_addr == 9'h118) |=> dq_out == 16'h0002)
		else $error("otp field count wrong");
	a_otp_lock: assert property (@(posedge clk) disable iff (rst) // [R12]
		(query_mode && rd_en && word_addr == 9'h119) |=> dq_out == 16'h0080)
		else $error("otp lock address wrong");
	a_prot_lock: assert property (@(posedge clk) disable iff (rst) // [R13]
		(query_mode && rd_en && word_addr == 9'h11D) |=> dq_out == 16'h0089)
		else $error("protection lock address wrong");
	a_page_size: assert property (@(posedge clk) disable iff (rst) // [R14]
		(query_mode && rd_en && word_addr == 9'h127 && !separate_bus_variant) |=> dq_out == 16'h0000)
		else $error("page size wrong");
	a_burst_count: assert property (@(posedge clk) disable iff (rst) // [R15]
		(query_mode && rd_en && word_addr == 9'h128) |=> dq_out == 16'h0003)
		else $error("burst config count wrong");
	a_burst_eight: assert property (@(posedge clk) disable iff (rst) // [R16]
		(query_mode && rd_en && word_addr == 9'h129) |=> dq_out == 16'h0002)
		else $error("eight word burst code wrong");
	a_burst_cont: assert property (@(posedge clk) disable iff (rst) // [R16]
		(query_mode && rd_en && word_addr == 9'h12B) |=> ##0 rd_valid && dq_out == 16'h0007)
		else $error("continuous burst code wrong");
	a_part_ops: assert property (@(posedge clk) disable iff (rst) // [R17]
		(query_mode && rd_en && word_addr == 9'h131) |=> dq_out == 16'h0011)
		else $error("partition op counts wrong");
	a_part_blocks: assert property (@(posedge clk) disable iff (rst) // [R18]
		(query_mode && rd_en && word_addr == 9'h135 && density == FQGT_D256) |=> dq_out == 16'h000F)
		else $error("partition block count wrong");
	a_sync_modes: assert property (@(posedge clk) disable iff (rst) // [R19]
		(query_mode && rd_en && word_addr == 9'h13C && separate_bus_variant) |=> dq_out == 16'h0003)
		else $error("read mode flags wrong");
	a_prog_region: assert property (@(posedge clk) disable iff (rst) // [R20]
		(query_mode && rd_en && word_addr == 9'h13D) |=> dq_out == 16'h000A)
		else $error("programming region size wrong");
	a_undef_zero: assert property (@(posedge clk) disable iff (rst) // [R21]
		(query_mode && rd_en && word_addr == 9'h1FF) |=> dq_out == 16'h0000)
		else $error("undefined address not zero");
	a_idle_quiet: assert property (@(posedge clk) disable iff (rst) !(query_mode && rd_en) |=> !dq_oe && !rd_valid)
		else $error("output driven without read");
endmodule

/* logic/fqgt_rom.sv */
// combinational query table contents
`timescale 1ns/1ps
`include "fqgt_consts.svh"
module fqgt_rom
	import fqgt_pkg::*;
(
	fqgt_rom_if.rom bus
);
	logic [2:0] burst_code [3];
	genvar      g;
	generate
		// burst codes for 8 words, 16 words and continuous
		for (g = 0; g < 3; g++) begin : g_burst
			fqgt_burst_enc u_enc (
				.len_log2   (5'(g + 3)),
				.continuous (g == 2),
				.code       (burst_code[g])
			);
		end
	endgenerate
	always_comb begin
		case (bus.addr)
			9'h027: begin
				case (bus.density) // [R2]
					FQGT_D256: bus.data = `FQGT_SIZE_256;
					FQGT_D512: bus.data = `FQGT_SIZE_512;
					default:   bus.data = `FQGT_SIZE_1G;
				endcase
			end
			9'h028: bus.data = 8'h01; // [R3]
			9'h02A: bus.data = 8'h0A; // [R4]
			9'h02C: bus.data = 8'h01; // [R5]
			9'h02D: bus.data = (bus.density == FQGT_D256) ? 8'h7F : 8'hFF; // [R6]
			9'h02E: bus.data = (bus.density == FQGT_D256 || bus.density == FQGT_D512) ? 8'h00 : 8'h01; // [R6]
			9'h030: bus.data = 8'h04; // [R6]
			9'h10A: bus.data = 8'h50; // [R7]
			9'h10B: bus.data = 8'h52; // [R7]
			9'h10C: bus.data = 8'h49; // [R7]
			9'h10D: bus.data = 8'h31; // [R7]
			9'h10E: bus.data = 8'h34; // [R7]
			9'h10F: bus.data = bus.sep_bus ? `FQGT_FEAT_SEP : `FQGT_FEAT_SHR; // [R8]
			9'h110: bus.data = 8'h07; // [R8]
			9'h113: bus.data = 8'h01; // [R9]
			9'h114: bus.data = 8'h33; // [R10]
			9'h116: bus.data = 8'h18; // [R11]
			9'h117: bus.data = 8'h90; // [R11]
			9'h118: bus.data = 8'h02; // [R12]
			9'h119: bus.data = 8'h80; // [R12]
			9'h11B: bus.data = 8'h03; // [R12]
			9'h11C: bus.data = 8'h03; // [R12]
			9'h11D: bus.data = 8'h89; // [R13]
			9'h124: bus.data = 8'h10; // [R13]
			9'h126: bus.data = 8'h04; // [R13]
			9'h127: bus.data = bus.sep_bus ? `FQGT_PAGE_SEP : `FQGT_PAGE_SHR; // [R14]
			9'h128: bus.data = 8'h03; // [R15]
			9'h129: bus.data = {5'h00, burst_code[0]}; // [R15] [R16]
			9'h12A: bus.data = {5'h00, burst_code[1]}; // [R15] [R16]
			9'h12B: bus.data = {5'h00, burst_code[2]}; // [R15] [R16]
			9'h12C: bus.data = 8'h01; // [R17]
			9'h12D: bus.data = 8'h16; // [R17]
			9'h12F: bus.data = 8'h08; // [R17]
			9'h131: bus.data = 8'h11; // [R17]
			9'h134: bus.data = 8'h01; // [R18]
			9'h135: begin
				case (bus.density) // [R18]
					FQGT_D256: bus.data = 8'h0F;
					FQGT_D512: bus.data = 8'h1F;
					default:   bus.data = 8'h3F;
				endcase
			end
			9'h138: bus.data = 8'h04; // [R18]
			9'h139: bus.data = 8'h64; // [R19]
			9'h13B: bus.data = 8'h12; // [R19]
			9'h13C: bus.data = bus.sep_bus ? `FQGT_SYNC_SEP : `FQGT_SYNC_SHR; // [R19]
			9'h13D: bus.data = 8'h0A; // [R20]
			9'h13F: bus.data = 8'h10; // [R20]
			9'h141: bus.data = 8'h10; // [R20]
			default: bus.data = 8'h00; // [R21]
		endcase
	end
endmodule

/* verification/fqgt_host.sv */
// host side query reader that captures a burst code
`timescale 1ns/1ps
module fqgt_host (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] dq_out,
	input  wire logic        rd_valid,
	output logic             query_mode,
	output logic             rd_en,
	output logic      [8:0]  word_addr,
	output logic      [2:0]  read_config_word
);
	logic [8:0] taken_r;
	initial begin
		query_mode = 1'b0;
		rd_en = 1'b0;
		word_addr = 9'h000;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			taken_r <= 9'h000;
			read_config_word <= 3'h0;
		end else begin
			if (query_mode && rd_en)
				taken_r <= word_addr;
			if (rd_valid && taken_r >= 9'h129 && taken_r <= 9'h12B)
				read_config_word <= dq_out[2:0];
		end
	end
	task read_word(input logic [8:0] a, input logic qm);
		@(posedge clk);
		#1;
		query_mode = qm;
		rd_en = 1'b1;
		word_addr = a;
	endtask
	task idle();
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		word_addr = ~word_addr;
	endtask
endmodule

/* verification/fqgt_query_bench.sv */
// bench sweeping the query table against a reference model
`timescale 1ns/1ps
module fqgt_query_bench;
	import fqgt_pkg::*;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          query_mode, rd_en, separate_bus_variant, dq_oe, rd_valid, exp_v;
	logic [8:0]    word_addr;
	logic [15:0]   dq_out, exp_d;
	logic [2:0]    rcw;
	fqgt_density_e density = FQGT_D256;
	int            n_mismatch = 0, n_compared = 0, d_i = 0, s_i = 0;
	always #20 clk = ~clk;
	fqgt_query fqgt_query_i (.clk(clk), .rst(rst), .query_mode(query_mode), .rd_en(rd_en),
		.word_addr(word_addr), .density(density), .separate_bus_variant(separate_bus_variant),
		.dq_out(dq_out), .dq_oe(dq_oe), .rd_valid(rd_valid));
	fqgt_host fqgt_host_i (.clk(clk), .rst(rst), .dq_out(dq_out), .rd_valid(rd_valid),
		.query_mode(query_mode), .rd_en(rd_en), .word_addr(word_addr), .read_config_word(rcw));
	assign separate_bus_variant = s_i[0];
	function automatic logic [15:0] model(logic [8:0] a, int d, int s);
		logic [7:0] v;
		case (a)
			9'h027: v = d == 0 ? 8'h19 : d == 1 ? 8'h1A : 8'h1B;
			9'h028, 9'h02C, 9'h113, 9'h12C, 9'h134: v = 8'h01;
			9'h02A, 9'h13D: v = 8'h0A;
			9'h02D: v = d == 0 ? 8'h7F : 8'hFF;
			9'h02E: v = d >= 2 ? 8'h01 : 8'h00;
			9'h030, 9'h126, 9'h138: v = 8'h04;
			9'h10A: v = 8'h50;
			9'h10B: v = 8'h52;
			9'h10C: v = 8'h49;
			9'h10D: v = 8'h31;
			9'h10E: v = 8'h34;
			9'h10F: v = s != 0 ? 8'hE6 : 8'h66;
			9'h110, 9'h12B: v = 8'h07;
			9'h114: v = 8'h33;
			9'h116: v = 8'h18;
			9'h117: v = 8'h90;
			9'h118, 9'h129: v = 8'h02;
			9'h119: v = 8'h80;
			9'h11B, 9'h11C, 9'h128, 9'h12A: v = 8'h03;
			9'h11D: v = 8'h89;
			9'h124, 9'h13F, 9'h141: v = 8'h10;
			9'h127: v = s != 0 ? 8'h05 : 8'h00;
			9'h12D: v = 8'h16;
			9'h12F: v = 8'h08;
			9'h131: v = 8'h11;
			9'h135: v = d == 0 ? 8'h0F : d == 1 ? 8'h1F : 8'h3F;
			9'h139: v = 8'h64;
			9'h13B: v = 8'h12;
			9'h13C: v = s != 0 ? 8'h03 : 8'h02;
			default: v = 8'h00;
		endcase
		return {8'h00, v};
	endfunction
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			exp_v <= 1'b0;
			exp_d <= 16'h0000;
		end else begin
			exp_v <= query_mode && rd_en;
			if (query_mode && rd_en)
				exp_d <= model(word_addr, d_i, s_i);
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] expd);
		n_compared++;
		if (seen !== expd) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask
	always @(negedge clk) begin
		check({15'h0000, rd_valid}, {15'h0000, exp_v});
		check({15'h0000, dq_oe}, {15'h0000, exp_v});
		check(dq_out, exp_d);
	end
	task conclude();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(40 * 20000);
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(87492));
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		for (d_i = 0; d_i < 4; d_i++) begin
			for (s_i = 0; s_i < 2; s_i++) begin
				density = fqgt_density_e'(d_i[1:0]);
				for (int a = 0; a < 512; a++) begin
					if ($urandom % 8 == 0)
						fqgt_host_i.read_word(a[8:0], 1'b0);
					fqgt_host_i.read_word(a[8:0], 1'b1);
					if ($urandom % 4 == 0)
						fqgt_host_i.idle();
				end
				fqgt_host_i.idle();
				check({13'h0000, rcw}, {13'h0000, 3'h7});
				if (d_i == 1 && s_i == 1) begin
					rst = 1'b1;
					repeat (2) @(posedge clk);
					#1;
					rst = 1'b0;
				end
			end
		end
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule
